// ---- hw/alarm_pkg.sv ----
// ==========================================================
// shared constants for the alarm interrupt block
package alarm_pkg;

  // register offsets
  localparam logic [7:0] ctrl_status_addr   = 8'h01;
  localparam logic [7:0] cur_minutes_addr   = 8'h03;
  localparam logic [7:0] cur_hours_addr     = 8'h04;
  localparam logic [7:0] cur_date_addr      = 8'h05;
  localparam logic [7:0] cur_weekday_addr   = 8'h06;
  localparam logic [7:0] alarm_minute_addr  = 8'h09;
  localparam logic [7:0] alarm_hour_addr    = 8'h0a;
  localparam logic [7:0] alarm_date_addr    = 8'h0b;
  localparam logic [7:0] alarm_weekday_addr = 8'h0c;
  localparam logic [7:0] irq_status_addr    = 8'h10;
  localparam logic [7:0] irq_mask_addr      = 8'h11;

  // control/status field positions, and the alarm register exclude bit
  localparam int timer_irq_enable_bit    = 0;
  localparam int alarm_irq_enable_bit    = 1;
  localparam int timer_flag_bit          = 2;
  localparam int alarm_flag_bit          = 3;
  localparam int timer_repeat_select_bit = 4;
  localparam int alarm_field_exclude_bit = 7;

  // field value masks per alarm register, and the control/status read mask
  localparam logic [7:0] minute_mask  = 8'h7f;
  localparam logic [7:0] hour_mask    = 8'h3f;
  localparam logic [7:0] date_mask    = 8'h3f;
  localparam logic [7:0] weekday_mask = 8'h07;
  localparam logic [7:0] ctrl_mask    = 8'h1f;

  // reset values
  localparam logic [7:0] reg_reset_val   = 8'h00;
  localparam logic [7:0] alarm_reset_val = 8'h80;

  // status bit positions of the interrupt status register
  localparam int evt_alarm_bit = 0;
  localparam int evt_timer_bit = 1;

  // match tracker states
  typedef enum logic [0:0] {
    match_idle = 1'b0,
    match_held = 1'b1
  } match_state_t;

endpackage : alarm_pkg

// ---- hw/alarm_compare.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// per-field compare with exclude bits
module alarm_compare (
  // alarm targets, exclude bit in msb
  input  wire logic [7:0] minute_tgt_in,
  input  wire logic [7:0] hour_tgt_in,
  input  wire logic [7:0] date_tgt_in,
  input  wire logic [7:0] weekday_tgt_in,
  // current time
  input  wire logic [7:0] minute_now_in,
  input  wire logic [7:0] hour_now_in,
  input  wire logic [7:0] date_now_in,
  input  wire logic [7:0] weekday_now_in,
  // result
  output var  logic       match_out
);
  import alarm_pkg::*;

  logic [3:0] field_hit;
  logic [3:0] field_excl;
  logic [7:0] tgt [4];
  logic [7:0] now [4];
  logic [7:0] msk [4];

  // gather fields into arrays
  always_comb begin
    tgt[0] = minute_tgt_in;
    tgt[1] = hour_tgt_in;
    tgt[2] = date_tgt_in;
    tgt[3] = weekday_tgt_in;
    now[0] = minute_now_in;
    now[1] = hour_now_in;  // 24-hour compare
    now[2] = date_now_in;
    now[3] = weekday_now_in;
    msk[0] = minute_mask;
    msk[1] = hour_mask;
    msk[2] = date_mask;
    msk[3] = weekday_mask;
  end

  // excluded field always passes
  for (genvar i = 0; i < 4; i++) begin : g_field
    assign field_excl[i] = tgt[i][alarm_field_exclude_bit];
    assign field_hit[i]  = field_excl[i] | ((tgt[i] & msk[i]) == (now[i] & msk[i]));
  end

  // all excluded never matches
  assign match_out = (&field_hit) & ~(&field_excl);

endmodule : alarm_compare
`default_nettype wire

// ---- hw/rtc_alarm_irq.sv ----
`timescale 1ns/1ns
`default_nettype none
module rtc_alarm_irq (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  // register port
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output var  logic [7:0] rdata_out,
  // timer event from the countdown logic
  input  wire logic       timer_event_in,
  // shared open-drain interrupt pin
  output var  logic       alarm_irq_out_n,
  output var  logic       alarm_irq_oe_n_out,
  // level interrupt to local cpu
  output var  logic       irq_out
);
  import alarm_pkg::*;

  // ==========================================================
  // registers
  logic [7:0]   ctrl_ff;
  logic [7:0]   cur_min_ff;
  logic [7:0]   cur_hour_ff;
  logic [7:0]   cur_date_ff;
  logic [7:0]   cur_wday_ff;
  logic [7:0]   al_min_ff;
  logic [7:0]   al_hour_ff;
  logic [7:0]   al_date_ff;
  logic [7:0]   al_wday_ff;
  logic [1:0]   status_ff;
  logic [1:0]   mask_ff;
  match_state_t match_ff;
  logic         match_now;
  logic         alarm_event;
  logic         wr_ctrl;
  logic         nxt_pin_low;
  logic [7:0]   nxt_rdata;

  assign wr_ctrl = wr_in && (addr_in == ctrl_status_addr);

  // ==========================================================
  // time and alarm target registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cur_min_ff  <= reg_reset_val;
      cur_hour_ff <= reg_reset_val;
      cur_date_ff <= reg_reset_val;
      cur_wday_ff <= reg_reset_val;
      al_min_ff   <= alarm_reset_val;
      al_hour_ff  <= alarm_reset_val;
      al_date_ff  <= alarm_reset_val;
      al_wday_ff  <= alarm_reset_val;
    end else if (wr_in) begin
      case (addr_in)
        cur_minutes_addr:   cur_min_ff  <= wdata_in & minute_mask;
        cur_hours_addr:     cur_hour_ff <= wdata_in & hour_mask;
        cur_date_addr:      cur_date_ff <= wdata_in & date_mask;
        cur_weekday_addr:   cur_wday_ff <= wdata_in & weekday_mask;
        alarm_minute_addr:  al_min_ff   <= wdata_in;
        alarm_hour_addr:    al_hour_ff  <= wdata_in & (hour_mask | alarm_reset_val);
        alarm_date_addr:    al_date_ff  <= wdata_in & (date_mask | alarm_reset_val);
        alarm_weekday_addr: al_wday_ff  <= wdata_in & (weekday_mask | alarm_reset_val);
        default: ;
      endcase
    end
  end

  // ==========================================================
  // comparison
  alarm_compare u_compare (
    .minute_tgt_in  (al_min_ff),
    .hour_tgt_in    (al_hour_ff),
    .date_tgt_in    (al_date_ff),
    .weekday_tgt_in (al_wday_ff),
    .minute_now_in  (cur_min_ff),
    .hour_now_in    (cur_hour_ff),
    .date_now_in    (cur_date_ff),
    .weekday_now_in (cur_wday_ff),
    .match_out      (match_now)
  );

  // track match level so only rising edge counts
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      match_ff <= match_idle;
    end else begin
      case (match_ff)
        match_idle: if (match_now) match_ff <= match_held;
        match_held: if (!match_now) match_ff <= match_idle;
        default:    match_ff <= match_idle;
      endcase
    end
  end

  assign alarm_event = match_now && (match_ff == match_idle);

  // ==========================================================
  // control/status register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_ff <= reg_reset_val;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff[timer_irq_enable_bit]    <= wdata_in[timer_irq_enable_bit];
        ctrl_ff[alarm_irq_enable_bit]    <= wdata_in[alarm_irq_enable_bit];
        ctrl_ff[timer_repeat_select_bit] <= wdata_in[timer_repeat_select_bit];
        // flags clear on zero, keep on one
        if (!wdata_in[alarm_flag_bit]) ctrl_ff[alarm_flag_bit] <= 1'b0;
        if (!wdata_in[timer_flag_bit]) ctrl_ff[timer_flag_bit] <= 1'b0;
      end
      // set wins over clear, set regardless of enable
      if (alarm_event) ctrl_ff[alarm_flag_bit] <= 1'b1;
      if (timer_event_in) ctrl_ff[timer_flag_bit] <= 1'b1;
    end
  end

  // ==========================================================
  // shared pin, driven from flag and enable levels
  always_comb begin
    nxt_pin_low = (ctrl_ff[alarm_flag_bit] && ctrl_ff[alarm_irq_enable_bit])
               || (ctrl_ff[timer_flag_bit] && ctrl_ff[timer_irq_enable_bit]);
  end

  // pin register; released when each source has its flag or enable clear
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      alarm_irq_out_n    <= 1'b1;
      alarm_irq_oe_n_out <= 1'b1;
    end else begin
      alarm_irq_out_n    <= 1'b0;
      alarm_irq_oe_n_out <= ~nxt_pin_low;
    end
  end

  // ==========================================================
  // local interrupt: sticky status, write one clears
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      status_ff <= 2'h0;
      mask_ff   <= 2'h0;
    end else begin
      if (wr_in && addr_in == irq_mask_addr) mask_ff <= wdata_in[1:0];
      status_ff <= (status_ff & ~((wr_in && addr_in == irq_status_addr) ? wdata_in[1:0] : 2'h0))
                 | {timer_event_in, alarm_event};
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) irq_out <= 1'b0;
    else          irq_out <= |(status_ff & mask_ff);
  end

  // ==========================================================
  // read data, one cycle after the strobe
  always_comb begin
    nxt_rdata = 8'h00;
    case (addr_in)
      ctrl_status_addr:   nxt_rdata = ctrl_ff & ctrl_mask;
      cur_minutes_addr:   nxt_rdata = cur_min_ff;
      cur_hours_addr:     nxt_rdata = cur_hour_ff;
      cur_date_addr:      nxt_rdata = cur_date_ff;
      cur_weekday_addr:   nxt_rdata = cur_wday_ff;
      alarm_minute_addr:  nxt_rdata = al_min_ff;
      alarm_hour_addr:    nxt_rdata = al_hour_ff;
      alarm_date_addr:    nxt_rdata = al_date_ff;
      alarm_weekday_addr: nxt_rdata = al_wday_ff;
      irq_status_addr:    nxt_rdata = {6'h00, status_ff};
      irq_mask_addr:      nxt_rdata = {6'h00, mask_ff};
      default:            nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in)   rdata_out <= 8'h00;
    else if (rd_in) rdata_out <= nxt_rdata;
    else            rdata_out <= 8'h00;
  end

  // ==========================================================
  // checks
  a_flag_on_match: assert property (@(posedge clk_in) disable iff (reset_in)
    alarm_event |=> ctrl_ff[alarm_flag_bit])
    else $error("alarm flag not set on match");
  a_pin_low_en: assert property (@(posedge clk_in) disable iff (reset_in)
    (ctrl_ff[alarm_flag_bit] && ctrl_ff[alarm_irq_enable_bit]) |=> !alarm_irq_oe_n_out)
    else $error("pin not driven on enabled alarm");
  a_all_excluded: assert property (@(posedge clk_in) disable iff (reset_in)
    (al_min_ff[7] && al_hour_ff[7] && al_date_ff[7] && al_wday_ff[7]) |-> !match_now)
    else $error("match with all fields excluded");
  a_flag_clear: assert property (@(posedge clk_in) disable iff (reset_in)
    (wr_ctrl && !wdata_in[alarm_flag_bit] && !alarm_event) |=> !ctrl_ff[alarm_flag_bit])
    else $error("flag not cleared by zero write");
  a_flag_sticky: assert property (@(posedge clk_in) disable iff (reset_in)
    (ctrl_ff[alarm_flag_bit] && !(wr_ctrl && !wdata_in[alarm_flag_bit]))
      |=> ctrl_ff[alarm_flag_bit])
    else $error("flag lost without clear");
  a_release_dis: assert property (@(posedge clk_in) disable iff (reset_in)
    (!ctrl_ff[alarm_irq_enable_bit] && !ctrl_ff[timer_irq_enable_bit]) |=> alarm_irq_oe_n_out)
    else $error("pin driven with enables off");
  a_single_event: assert property (@(posedge clk_in) disable iff (reset_in)
    alarm_event |=> !alarm_event)
    else $error("repeated event on held match");
  a_flag_no_enable: assert property (@(posedge clk_in) disable iff (reset_in)
    (alarm_event && !ctrl_ff[alarm_irq_enable_bit]) |=> ctrl_ff[alarm_flag_bit])
    else $error("flag not set with enable off");
  a_pin_release: assert property (@(posedge clk_in) disable iff (reset_in)
    (!ctrl_ff[alarm_flag_bit] && !ctrl_ff[timer_flag_bit]) |=> alarm_irq_oe_n_out)
    else $error("pin held after flags cleared");

  c_alarm_event: cover property (@(posedge clk_in) disable iff (reset_in) alarm_event);
  c_pin_low: cover property (@(posedge clk_in) disable iff (reset_in) !alarm_irq_oe_n_out);
  c_late_enable: cover property (@(posedge clk_in) disable iff (reset_in)
    (ctrl_ff[alarm_flag_bit] && !ctrl_ff[alarm_irq_enable_bit])
      ##1 ctrl_ff[alarm_irq_enable_bit]);

endmodule : rtc_alarm_irq
`default_nettype wire

// ---- verification/irq_line_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// far side: pulled-up shared pin and timer event source
module irq_line_model (
  // clock
  input  wire logic clk_in,
  // pin as driven by the block
  input  wire logic drive_n_in,
  input  wire logic level_n_in,
  // timer request from the bench
  input  wire logic fire_in,
  // resolved pin and timer pulse
  output var  logic pin_out,
  output var  logic timer_event_out
);
  // pull-up wins while released; low only when driven
  assign pin_out = drive_n_in ? 1'b1 : level_n_in;
  // one-cycle timer pulse per request
  always_ff @(posedge clk_in) begin
    timer_event_out <= fire_in;
  end
endmodule : irq_line_model
`default_nettype wire

// ---- verification/test_rtc_alarm_irq.sv ----
`timescale 1ns/1ns
`default_nettype none
`define chk(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
// ==========================================================
// bench for the alarm interrupt block
module test_rtc_alarm_irq;
  import alarm_pkg::*;
  logic        clk_in, reset_in, wr_in, rd_in, fire, tev, pin, irq, pin_n, oe_n;
  logic [7:0]  addr_in, wdata_in, rdata, m;
  logic [31:0] seed;
  int          n_mismatch, checks;
  logic [7:0]  a_addr [4];
  logic [7:0]  a_msk  [4];

  rtc_alarm_irq i_dut (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
    .timer_event_in(tev), .alarm_irq_out_n(pin_n), .alarm_irq_oe_n_out(oe_n),
    .irq_out(irq));
  irq_line_model i_line (.clk_in(clk_in), .drive_n_in(oe_n), .level_n_in(pin_n),
    .fire_in(fire), .pin_out(pin), .timer_event_out(tev));

  // clock and watchdog
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    repeat (3000) @(posedge clk_in);
    n_mismatch++;
    conclude();
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1;
    `chk(rdata, e)
  endtask : rd
  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  // ========================================================
  // main sequence
  initial begin
    a_addr = '{alarm_minute_addr, alarm_hour_addr, alarm_date_addr, alarm_weekday_addr};
    a_msk  = '{minute_mask, hour_mask, date_mask, weekday_mask};
    {reset_in, wr_in, rd_in, fire, addr_in, wdata_in} = '0;
    reset_in = 1'b1;
    seed = 32'ha8fa;
    n_mismatch = 0;
    checks = 0;
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    // reset values, unmapped place
    for (int i = 0; i < 4; i++) rd(a_addr[i], 8'h80);
    rd(ctrl_status_addr, 8'h00);
    wr(8'h02, 8'hff);
    rd(8'h02, 8'h00);
    `chk(pin, 1'b1)
    // random target read-back
    for (int i = 0; i < 8; i++) begin
      seed = nxt(seed);
      wr(a_addr[i % 4], seed[7:0]);
      rd(a_addr[i % 4], seed[7:0] & (8'h80 | a_msk[i % 4]));
    end
    // minute and 24-hour match, enable off
    m = seed[15:8] & 8'h59;
    wr(ctrl_status_addr, 8'h00);
    wr(cur_minutes_addr, m ^ 8'h01);
    wr(cur_hours_addr, 8'h19);
    wr(alarm_minute_addr, m);
    wr(alarm_hour_addr, 8'h19);
    wr(alarm_date_addr, 8'h80);
    wr(alarm_weekday_addr, 8'h80);
    // random targets may have matched on the way here
    wr(ctrl_status_addr, 8'h00);
    cyc(3);
    rd(ctrl_status_addr, 8'h00);
    wr(cur_minutes_addr, m);
    cyc(3);
    `chk(pin, 1'b1)
    rd(ctrl_status_addr, 8'h08);
    wr(ctrl_status_addr, 8'h0a);
    cyc(3);
    `chk(pin, 1'b0)
    rd(ctrl_status_addr, 8'h0a);
    cyc(20);
    `chk(pin, 1'b0)
    rd(ctrl_status_addr, 8'h0a);
    wr(ctrl_status_addr, 8'h08);
    cyc(3);
    `chk(pin, 1'b1)
    rd(ctrl_status_addr, 8'h08);
    wr(ctrl_status_addr, 8'h0a);
    wr(ctrl_status_addr, 8'h02);
    cyc(3);
    `chk(pin, 1'b1)
    cyc(10);
    rd(ctrl_status_addr, 8'h02);
    wr(cur_hours_addr, 8'h07);
    cyc(3);
    rd(ctrl_status_addr, 8'h02);
    wr(cur_hours_addr, 8'h19);
    cyc(3);
    `chk(pin, 1'b0)
    // all excluded, then only hour compared
    wr(ctrl_status_addr, 8'h00);
    wr(alarm_minute_addr, 8'h80);
    wr(alarm_hour_addr, 8'h80);
    wr(ctrl_status_addr, 8'h02);
    wr(cur_minutes_addr, m ^ 8'h01);
    wr(cur_hours_addr, 8'h07);
    wr(cur_hours_addr, 8'h19);
    cyc(3);
    `chk(pin, 1'b1)
    rd(ctrl_status_addr, 8'h02);
    wr(alarm_hour_addr, 8'h19);
    cyc(3);
    `chk(pin, 1'b0)
    // timer shares the pin; local interrupt and mask
    wr(ctrl_status_addr, 8'h00);
    @(posedge clk_in);
    fire <= 1'b1;
    @(posedge clk_in);
    fire <= 1'b0;
    cyc(3);
    `chk(pin, 1'b1)
    rd(ctrl_status_addr, 8'h04);
    rd(irq_status_addr, 8'h03);
    `chk(irq, 1'b0)
    wr(irq_mask_addr, 8'h02);
    cyc(2);
    `chk(irq, 1'b1)
    wr(ctrl_status_addr, 8'h05);
    cyc(3);
    `chk(pin, 1'b0)
    wr(ctrl_status_addr, 8'h01);
    wr(irq_status_addr, 8'h03);
    cyc(3);
    `chk(pin, 1'b1)
    `chk(irq, 1'b0)
    rd(irq_status_addr, 8'h00);
    conclude();
  end
endmodule : test_rtc_alarm_irq
`default_nettype wire
